// file: sdim_map.svh
// register map, reset values and timing counts of the idle/loop/mode registers
`ifndef SDIM_MAP_SVH
`define SDIM_MAP_SVH

`define SDIM_OFS_IDLE_LO   8'h0d
`define SDIM_OFS_IDLE_HI   8'h0e
`define SDIM_OFS_RSV_FIRST 8'h0f
`define SDIM_OFS_RSV_LAST  8'h1c
`define SDIM_OFS_STATUS    8'h1d
`define SDIM_OFS_GPIO      8'h1e
`define SDIM_OFS_VARIANT   8'h1f

`define SDIM_STAT_LOOP_BIT 5
`define SDIM_STAT_MODE_LSB 0
`define SDIM_GPIO0_BIT     0
`define SDIM_MODE_ASI      2'h3

`define SDIM_K28_5         10'h0fa
`define SDIM_GPIO_RST      1'h0

`define SDIM_WORD_DIV      3'h4
`define SDIM_STRAP_WAIT    2'h2
`define SDIM_BITS_PER_BYTE 4'h8

`endif

// file: sdim_pkg.sv
// types shared by the idle/loop/mode register block
package sdim_pkg;
  typedef enum logic [6:0] {
    SDIM_IDLE = 7'h01,
    SDIM_ADDR = 7'h02,
    SDIM_ACK  = 7'h04,
    SDIM_RX   = 7'h08,
    SDIM_TX   = 7'h10,
    SDIM_MACK = 7'h20,
    SDIM_WAIT = 7'h40
  } sdim_state_t;
endpackage

// file: sdim_regs.sv
// idle-insertion datapath, word fifo and smbus register slave
`timescale 1ns/1ps
`include "sdim_map.svh"

module sdim_fifo
  import sdim_pkg::*;
#(
  parameter int W = 10,
  parameter int D = 8
)(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_r   [D];
  logic [W-1:0]  mem_nxt [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] wp_nxt;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          full_r;
  logic          full_nxt;
  logic          empty_r;
  logic          empty_nxt;
  logic          rdy_r;
  logic          rdy_nxt;
  logic          push;
  logic          pop;

  always_comb
  begin
    mem_nxt = mem_r;
    push    = in_valid & ~full_r;
    pop     = out_ready & ~empty_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    if (push)
    begin
      mem_nxt[wp_r] = in_data;
      wp_nxt        = (wp_r == AW'(D - 1)) ? '0 : wp_r + AW'(1);
    end
    if (pop)
      rp_nxt = (rp_r == AW'(D - 1)) ? '0 : rp_r + AW'(1);
    cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    full_nxt  = (cnt_nxt == (AW+1)'(D));
    empty_nxt = (cnt_nxt == '0);
    rdy_nxt   = ~full_nxt;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < D; i++)
        mem_r[i] <= '0;
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= '0;
      full_r  <= 1'b0;
      empty_r <= 1'b1;
      rdy_r   <= 1'b1;
    end
    else
    begin
      mem_r   <= mem_nxt;
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      cnt_r   <= cnt_nxt;
      full_r  <= full_nxt;
      empty_r <= empty_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  // own flop so the ready port needs no gate after the full flag
  assign in_ready  = rdy_r;
  assign out_valid = ~empty_r;
  assign out_data  = mem_r[rp_r];
endmodule

module sdim_regs
  import sdim_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2d,  // arbitrary default
  parameter logic [7:0] VARIANT_ID = 8'h5a   // arbitrary value
)(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // smbus configuration port
  input  wire logic       scl_pin,
  input  wire logic       sda_pin_in,
  output logic            sda_pin_out,
  output logic            sda_pin_oe,
  // straps and device state
  input  wire logic       loop_en_pin,
  input  wire logic [1:0] mode_pin,
  // received words
  input  wire logic [9:0] rx_word,
  input  wire logic       rx_word_valid,
  output logic            rx_word_ready,
  // parallel output stream
  output logic [9:0]      par_word,
  output logic            par_word_stb,
  output logic            par_word_idle,
  // control outputs
  output logic            loop_en_out,
  output logic            gpio0_out,
  output logic            asi_mode
);
  // readback mux, shared by first byte and follow-on reads
  function automatic logic [7:0] reg_read(
    input logic [7:0] a,
    input logic [7:0] lo,
    input logic [1:0] hi,
    input logic       loop,
    input logic [1:0] mode,
    input logic       gpio
  );
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      `SDIM_OFS_IDLE_LO: d = lo;
      `SDIM_OFS_IDLE_HI: d = {6'h00, hi};
      `SDIM_OFS_STATUS:
      begin
        d[`SDIM_STAT_LOOP_BIT]                     = loop;
        d[`SDIM_STAT_MODE_LSB+1:`SDIM_STAT_MODE_LSB] = mode;
      end
      `SDIM_OFS_GPIO:    d[`SDIM_GPIO0_BIT] = gpio;
      `SDIM_OFS_VARIANT: d = VARIANT_ID;
      default:           d = 8'h00;
    endcase
    return d;
  endfunction

  // synchronisers: first stage feeds only the second
  logic [4:0]  sync1_r;
  logic [4:0]  sync2_r;
  logic        scl_q_r;
  logic        sda_q_r;
  logic        scl_s;
  logic        sda_s;
  logic        loop_pin_s;
  logic [1:0]  mode_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 5'h03;
      sync2_r <= 5'h03;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      sync1_r <= {mode_pin, loop_en_pin, sda_pin_in, scl_pin};
      sync2_r <= sync1_r;
      scl_q_r <= sync2_r[0];
      sda_q_r <= sync2_r[1];
    end
  end

  assign scl_s      = sync2_r[0];
  assign sda_s      = sync2_r[1];
  assign loop_pin_s = sync2_r[2];
  assign mode_s     = sync2_r[4:3];
  assign scl_rise   = scl_s & ~scl_q_r;
  assign scl_fall   = ~scl_s & scl_q_r;
  // data edges only count while clock is high and steady
  assign start_det  = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det   = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // register slave state
  sdim_state_t st_r;
  sdim_state_t st_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [7:0]  sh_r;
  logic [7:0]  sh_nxt;
  logic [7:0]  ptr_r;
  logic [7:0]  ptr_nxt;
  logic        cmd_r;
  logic        cmd_nxt;
  logic        rw_r;
  logic        rw_nxt;
  logic        nack_r;
  logic        nack_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic [7:0]  idle_lo_r;
  logic [7:0]  idle_lo_nxt;
  logic [1:0]  idle_hi_r;
  logic [1:0]  idle_hi_nxt;
  logic        loop_r;
  logic        loop_nxt;
  logic        gpio_r;
  logic        gpio_nxt;
  logic [1:0]  strap_r;
  logic [1:0]  strap_nxt;
  logic [1:0]  mode_r;
  logic        asi_r;
  logic        asi_nxt;
  logic [7:0]  rd;

  always_comb
  begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    sh_nxt      = sh_r;
    ptr_nxt     = ptr_r;
    cmd_nxt     = cmd_r;
    rw_nxt      = rw_r;
    nack_nxt    = nack_r;
    oe_nxt      = oe_r;
    idle_lo_nxt = idle_lo_r;
    idle_hi_nxt = idle_hi_r;
    loop_nxt    = loop_r;
    gpio_nxt    = gpio_r;
    strap_nxt   = strap_r;
    rd          = 8'h00;
    asi_nxt     = (mode_s == `SDIM_MODE_ASI);
    // strap taken once the pin synchroniser has filled
    if (strap_r != 2'h3)
    begin
      strap_nxt = strap_r + 2'h1;
      if (strap_r == `SDIM_STRAP_WAIT)
        loop_nxt = loop_pin_s;
    end
    if (stop_det)
    begin
      st_nxt = SDIM_IDLE;
      oe_nxt = 1'b0;
    end
    else if (start_det)
    begin
      st_nxt  = SDIM_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end
    else
    begin
      unique case (st_r)
        SDIM_IDLE, SDIM_WAIT: ;
        SDIM_ADDR, SDIM_RX:
        begin
          if (scl_rise)
          begin
            sh_nxt  = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == `SDIM_BITS_PER_BYTE)
          begin
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b1;
            st_nxt  = SDIM_ACK;
            if (st_r == SDIM_ADDR)
            begin
              rw_nxt  = sh_r[0];
              cmd_nxt = ~sh_r[0];
              // foreign address: stay off the bus until stop or a new start
              if (sh_r[7:1] != SLAVE_ADDR)
              begin
                oe_nxt = 1'b0;
                st_nxt = SDIM_WAIT;
              end
            end
            else if (cmd_r)
            begin
              ptr_nxt = sh_r;
              cmd_nxt = 1'b0;
            end
            else
            begin
              unique case (ptr_r)
                `SDIM_OFS_IDLE_LO: idle_lo_nxt = sh_r;
                `SDIM_OFS_IDLE_HI: idle_hi_nxt = sh_r[1:0];
                `SDIM_OFS_STATUS:  loop_nxt = sh_r[`SDIM_STAT_LOOP_BIT];
                `SDIM_OFS_GPIO:    gpio_nxt = sh_r[`SDIM_GPIO0_BIT];
                default: ;
              endcase
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        SDIM_ACK:
        begin
          if (scl_fall)
          begin
            cnt_nxt = 4'h0;
            if (rw_r)
            begin
              rd     = reg_read(ptr_r, idle_lo_r, idle_hi_r, loop_r, mode_r, gpio_r);
              sh_nxt = rd;
              oe_nxt = ~rd[7];
              st_nxt = SDIM_TX;
            end
            else
            begin
              oe_nxt = 1'b0;
              st_nxt = SDIM_RX;
            end
          end
        end
        SDIM_TX:
        begin
          if (scl_rise)
            cnt_nxt = cnt_r + 4'h1;
          else if (scl_fall)
          begin
            if (cnt_r == `SDIM_BITS_PER_BYTE)
            begin
              oe_nxt  = 1'b0;
              cnt_nxt = 4'h0;
              st_nxt  = SDIM_MACK;
            end
            else
            begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        SDIM_MACK:
        begin
          if (scl_rise)
            nack_nxt = sda_s;
          else if (scl_fall)
          begin
            if (nack_r)
              st_nxt = SDIM_WAIT;
            else
            begin
              ptr_nxt = ptr_r + 8'h01;
              rd      = reg_read(ptr_r + 8'h01, idle_lo_r, idle_hi_r, loop_r, mode_r, gpio_r);
              sh_nxt  = rd;
              oe_nxt  = ~rd[7];
              st_nxt  = SDIM_TX;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r      <= SDIM_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      ptr_r     <= 8'h00;
      cmd_r     <= 1'b0;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      oe_r      <= 1'b0;
      idle_lo_r <= 8'(`SDIM_K28_5);
      idle_hi_r <= 2'(`SDIM_K28_5 >> 8);
      loop_r    <= 1'b0;
      gpio_r    <= `SDIM_GPIO_RST;
      strap_r   <= 2'h0;
      mode_r    <= 2'h0;
      asi_r     <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      sh_r      <= sh_nxt;
      ptr_r     <= ptr_nxt;
      cmd_r     <= cmd_nxt;
      rw_r      <= rw_nxt;
      nack_r    <= nack_nxt;
      oe_r      <= oe_nxt;
      idle_lo_r <= idle_lo_nxt;
      idle_hi_r <= idle_hi_nxt;
      loop_r    <= loop_nxt;
      gpio_r    <= gpio_nxt;
      strap_r   <= strap_nxt;
      mode_r    <= mode_s;
      asi_r     <= asi_nxt;
    end
  end

  // word stream: fifo absorbs bursts, divider paces the output
  logic [9:0]  fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;
  logic [2:0]  div_r;
  logic [2:0]  div_nxt;
  logic [9:0]  word_r;
  logic [9:0]  word_nxt;
  logic        stb_r;
  logic        stb_nxt;
  logic        idl_r;
  logic        idl_nxt;

  sdim_fifo #(
    .W (10),
    .D (8)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_data   (rx_word),
    .in_valid  (rx_word_valid),
    .in_ready  (rx_word_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  always_comb
  begin
    div_nxt  = div_r + 3'h1;
    word_nxt = word_r;
    stb_nxt  = 1'b0;
    idl_nxt  = idl_r;
    fifo_pop = 1'b0;
    if (div_r == `SDIM_WORD_DIV - 3'h1)
    begin
      div_nxt = 3'h0;
      stb_nxt = 1'b1;
      if (fifo_valid)
      begin
        fifo_pop = 1'b1;
        word_nxt = fifo_data;
        idl_nxt  = 1'b0;
      end
      else
      begin
        // no received word: fill the slot with the idle character
        word_nxt = {idle_hi_r, idle_lo_r};
        idl_nxt  = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r  <= 3'h0;
      word_r <= `SDIM_K28_5;
      stb_r  <= 1'b0;
      idl_r  <= 1'b1;
    end
    else
    begin
      div_r  <= div_nxt;
      word_r <= word_nxt;
      stb_r  <= stb_nxt;
      idl_r  <= idl_nxt;
    end
  end

  // open-drain line: only ever pulled low
  assign sda_pin_out   = 1'b0;
  assign sda_pin_oe    = oe_r;
  assign par_word      = word_r;
  assign par_word_stb  = stb_r;
  assign par_word_idle = idl_r;
  assign loop_en_out   = loop_r;
  assign gpio0_out     = gpio_r;
  assign asi_mode      = asi_r;
endmodule

// file: sdim_regs_assertions.sv
// concurrent checks on the stream and strap outputs of the register block
`timescale 1ns/1ps
module sdim_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // straps and stream input
  input wire logic       loop_en_pin,
  input wire logic [1:0] mode_pin,
  input wire logic       rx_word_valid,
  input wire logic       rx_word_ready,
  // outputs
  input wire logic [9:0] par_word,
  input wire logic       par_word_stb,
  input wire logic       par_word_idle,
  input wire logic       loop_en_out,
  input wire logic       asi_mode
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  stb_spacing_a: assert property (par_word_stb |=> !par_word_stb [*3] ##1 par_word_stb)
    else $error("strobe spacing wrong");
  word_hold_a: assert property (!par_word_stb |-> $stable(par_word) && $stable(par_word_idle))
    else $error("output word moved between strobes");
  // deepest case: seven words queued ahead at one slot each
  data_out_a: assert property (rx_word_valid && rx_word_ready |-> ##[1:48] par_word_stb && !par_word_idle)
    else $error("taken word never left");
  full_drain_a: assert property (!rx_word_ready |-> ##[0:4] par_word_stb && !par_word_idle)
    else $error("idle sent while words held");
  asi_set_a: assert property ((mode_pin == 2'h3) [*6] |-> asi_mode)
    else $error("asi flag missing");
  asi_clear_a: assert property ((mode_pin != 2'h3) [*6] |-> !asi_mode)
    else $error("asi flag while video");
  loop_strap_hi_a: assert property ($rose(rst_n) && loop_en_pin ##1 loop_en_pin [*3] |=> loop_en_out)
    else $error("loop enable not taken from pin");
  loop_strap_lo_a: assert property ($rose(rst_n) && !loop_en_pin ##1 !loop_en_pin [*3] |=> !loop_en_out)
    else $error("loop enable set without pin");
  cover property (!rx_word_ready);
  cover property (par_word_stb && !par_word_idle);
  cover property ($rose(asi_mode));
endmodule

bind sdim_regs sdim_chk u_chk (.ref_clk, .rst_n, .loop_en_pin, .mode_pin, .rx_word_valid,
  .rx_word_ready, .par_word, .par_word_stb, .par_word_idle, .loop_en_out, .asi_mode);

// file: sdim_host.sv
// host-side sink that collects the parallel words
`timescale 1ns/1ps
module sdim_host (
  // clock
  input wire logic       ref_clk,
  // parallel stream from the device
  input wire logic [9:0] par_word,
  input wire logic       par_word_stb,
  input wire logic       par_word_idle
);
  logic [9:0] data_q [$];
  logic [9:0] idle_w;
  // idle slots kept apart so the order check sees payload only
  always @(posedge ref_clk)
    if (par_word_stb && !par_word_idle)
      data_q.push_back(par_word);
    else if (par_word_stb)
      idle_w <= par_word;
endmodule

// file: sdi_deser_idle_loop_mode_regs_tb.sv
// self-checking bench for the idle/loop/mode register block
`timescale 1ns/1ps
`include "sdim_map.svh"
module sdi_deser_idle_loop_mode_regs_tb;
  localparam logic [6:0] SA  = 7'h2d;
  localparam logic [7:0] VID = 8'h96; // arbitrary variant value
  logic       ref_clk, rst_n, scl_pin, sda_m, loop_en_pin, rx_word_valid, ack;
  logic [1:0] mode_pin;
  logic [9:0] rx_word, par_word;
  logic       sda_pin_out, sda_pin_oe, rx_word_ready, par_word_stb, par_word_idle;
  logic       loop_en_out, gpio0_out, asi_mode;
  int         bad_count, n_tests;
  wire logic  sda_pin_in = sda_m & (sda_pin_out | ~sda_pin_oe);
  logic [7:0] t_ofs [7] = '{8'h0d, 8'h0e, 8'h0f, 8'h1c, 8'h1e, 8'h1f, 8'h1d};
  logic [7:0] t_wr  [7] = '{8'h3c, 8'hff, 8'hff, 8'ha5, 8'h01, 8'h00, 8'h20};
  logic [7:0] t_rd  [7] = '{8'h3c, 8'h03, 8'h00, 8'h00, 8'h01, VID, 8'h23};

  sdim_regs #(.SLAVE_ADDR(SA), .VARIANT_ID(VID)) DUT (.ref_clk, .rst_n, .scl_pin,
    .sda_pin_in, .sda_pin_out, .sda_pin_oe, .loop_en_pin, .mode_pin, .rx_word,
    .rx_word_valid, .rx_word_ready, .par_word, .par_word_stb, .par_word_idle,
    .loop_en_out, .gpio0_out, .asi_mode);
  sdim_host host (.ref_clk, .par_word, .par_word_stb, .par_word_idle);

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // one bus bit of 13 cycles; sending 1 releases the line so it reads too
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    hc(3);
    scl_pin = 1'b1;
    hc(3);
    r = sda_pin_in;
    hc(3);
    scl_pin = 1'b0;
    hc(4);
  endtask

  task automatic xbyte(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(1'b1, ack);
  endtask

  task automatic start;
    sda_m = 1'b1;
    hc(3);
    scl_pin = 1'b1;
    hc(3);
    sda_m = 1'b0;
    hc(3);
    scl_pin = 1'b0;
    hc(3);
  endtask

  task automatic stop;
    sda_m = 1'b0;
    hc(3);
    scl_pin = 1'b1;
    hc(3);
    sda_m = 1'b1;
    hc(6);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    start();
    xbyte({SA, 1'b0}, r);
    chk({9'h0, ack}, 10'h000);
    xbyte(a, r);
    xbyte(d, r);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    start();
    xbyte({SA, 1'b0}, r);
    xbyte(a, r);
    start();
    xbyte({SA, 1'b1}, r);
    xbyte(8'hff, d);
    stop();
  endtask

  // two-byte read: master acks the first byte so the pointer steps
  task automatic rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] r;
    start();
    xbyte({SA, 1'b0}, r);
    xbyte(a, r);
    start();
    xbyte({SA, 1'b1}, r);
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d0[i]);
    bitx(1'b0, ack);
    xbyte(8'hff, d1);
    stop();
  endtask

  task automatic wstb;
    for (int i = 0; i < 10; i++)
    begin
      @(negedge ref_clk);
      if (par_word_stb)
        return;
    end
    bad_count++;
    test_done();
  endtask

  initial
  begin
    logic [7:0] d;
    logic [7:0] d2;
    logic       full;
    int         sent;
    scl_pin = 1'b1;
    sda_m = 1'b1;
    rst_n = 1'b0;
    loop_en_pin = 1'b0;
    mode_pin = 2'h3;
    rx_word = 10'h000;
    rx_word_valid = 1'b0;
    bad_count = 0;
    n_tests = 0;
    full = 1'b0;
    sent = 0;
    hc(6);
    rst_n = 1'b1;
    hc(8);
    chk({9'h0, loop_en_out}, 10'h000);
    chk({9'h0, asi_mode}, 10'h001);
    chk({9'h0, par_word_idle}, 10'h001);
    chk({8'h0, sda_pin_oe, sda_pin_out}, 10'h000);
    for (int i = 0; i < 7; i++)
    begin
      wr(t_ofs[i], t_wr[i]);
      rd(t_ofs[i], d);
      chk({2'h0, d}, {2'h0, t_rd[i]});
    end
    chk({9'h0, gpio0_out}, 10'h001);
    chk({9'h0, loop_en_out}, 10'h001);
    for (int m = 0; m < 4; m++)
    begin
      mode_pin = 2'(m);
      hc(8);
      rd(8'h1d, d);
      chk({2'h0, d}, 10'(8'h20 + m));
      chk({9'h0, asi_mode}, {9'h0, m == 3});
    end
    wstb();
    chk(par_word, 10'h33c);
    chk({9'h0, par_word_idle}, 10'h001);
    chk(host.idle_w, 10'h33c);
    // back to back until the fifo refuses, then it drains one per slot
    for (int i = 0; i < 60; i++)
    begin
      @(negedge ref_clk);
      full |= !rx_word_ready;
      rx_word_valid = rx_word_ready && sent < 12;
      rx_word = 10'(10'h100 + sent);
      if (rx_word_valid)
        sent++;
    end
    rx_word_valid = 1'b0;
    hc(40);
    chk({9'h0, full}, 10'h001);
    chk(10'(host.data_q.size()), 10'h00c);
    for (int i = 0; i < 12; i++)
      chk(host.data_q[i], 10'(10'h100 + i));
    loop_en_pin = 1'b1;
    mode_pin = 2'h1;
    rst_n = 1'b0;
    hc(6);
    chk(par_word, `SDIM_K28_5);
    rst_n = 1'b1;
    hc(8);
    chk({9'h0, loop_en_out}, 10'h001);
    chk({9'h0, gpio0_out}, 10'h000);
    // foreign address: no ack, and the write behind it must not land
    start();
    xbyte({SA ^ 7'h01, 1'b0}, d);
    chk({9'h0, ack}, 10'h001);
    xbyte(8'h0d, d);
    xbyte(8'h00, d);
    stop();
    rd(8'h0d, d);
    chk({2'h0, d}, 10'h0fa);
    rd(8'h0e, d);
    chk({2'h0, d}, 10'h000);
    rd(8'h1d, d);
    chk({2'h0, d}, 10'h021);
    rd2(8'h1e, d, d2);
    chk({2'h0, d}, 10'h000);
    chk({2'h0, d2}, {2'h0, VID});
    wstb();
    chk(par_word, `SDIM_K28_5);
    chk(host.idle_w, `SDIM_K28_5);
    test_done();
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
endmodule
